// *** verilog/hrc_pkg.sv ***
// constants and types for the hub reset and configuration block
package hrc_pkg;
  // ============================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_RECOVER_NS  = 500000;
  localparam int T_UNIT_NS     = 2000000;
  localparam int T_LOAD_MAX_NS = 99500000;
  localparam int T_REQ_MAX_NS  = 5000000;
  localparam int RECOVER_CYC   = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNIT_CYC      = T_UNIT_NS / CLK_PERIOD_NS;
  localparam int LOAD_MAX_CYC  = T_LOAD_MAX_NS / CLK_PERIOD_NS;
  localparam int REQ_MAX_CYC   = T_REQ_MAX_NS / CLK_PERIOD_NS;
  localparam int CURRENT_STEP_MA = 2;
  // ============================================================
  // register map (indices; byte address is four times the index)
  localparam logic [5:0] IDX_CUR_SELF   = 6'h0e;
  localparam logic [5:0] IDX_CUR_BUS    = 6'h0f;
  localparam logic [5:0] IDX_PWR_ON_DLY = 6'h10;
  localparam logic [5:0] IDX_STATUS     = 6'h11;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] DEF_CURRENT    = 8'h32;
  localparam logic [7:0] DEF_PWR_ON_DLY = 8'h32;
  // ============================================================
  // start-up sequencer
  typedef enum logic [4:0] {
    ST_STRAP  = 5'b00001,
    ST_RECOV  = 5'b00010,
    ST_LOAD   = 5'b00100,
    ST_ATTACH = 5'b01000,
    ST_RUN    = 5'b10000
  } hrc_state_t;
endpackage

// *** verilog/hrc_top.sv ***
// hub reset sequencer, strap capture and power configuration registers
//
// Summary of operation
// RULE1: self-powered controller current register counts upstream draw in 2mA steps
// RULE2: stored 50 means 100mA and is the internal default for both currents
// RULE3: bus-powered controller current register counts upstream draw in 2mA steps
// RULE4: power-on delay register counts 2ms steps from port power-on to power good
// RULE5: reading an undefined register location returns zero
// RULE6: writing an undefined location changes nothing and reports no error
// RULE7: software writes only zero to reserved registers and bits
// RULE8: in strap mode all bits without a strap take internal defaults
// RULE9: green indicator pins sampled after reset release; config only in default mode
// RULE10: strapped-high indicator drives active low, strapped-low drives active high
// RULE11: reset source holds reset low at least 1us after supplies settle
// RULE12: during reset ports, port power and transceivers are off
// RULE13: reset aborts every transaction at once without saving state
// RULE14: reset returns every register to its default, mostly zero; code resets all three to 0 and loads 32h only in strap or serial-off mode
// RULE15: during reset oscillator, PLL and indicators are stopped
// RULE16: hub becomes operational 500us after reset release
// RULE17: once operational, load external configuration unless serial management is off
// RULE18: in strap mode attach is shown within 100ms of reset
// RULE19: host waits at least 100ms after attach before bus reset
// RULE20: each host request completes within 5ms once enumeration begins
`timescale 1ns/100ps
`default_nettype none
module hrc_top
  import hrc_pkg::*;
#(
  parameter int unsigned PORTS         = 3,
  parameter int unsigned RECOVER_CYC_P = RECOVER_CYC,
  parameter int unsigned UNIT_CYC_P    = UNIT_CYC,
  parameter int unsigned LOAD_MAX_CYC_P = LOAD_MAX_CYC,
  parameter int unsigned REQ_MAX_CYC_P = REQ_MAX_CYC
) (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic [7:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  input  wire logic             strap_mode_i,
  input  wire logic             smbus_off_i,
  input  wire logic             cfg_load_done_i,
  output logic                  cfg_load_req_o,
  input  wire logic [PORTS-1:0] led_green_i,
  input  wire logic [PORTS-1:0] led_on_i,
  output logic      [PORTS-1:0] led_green_o,
  output logic      [PORTS-1:0] led_green_oe_o,
  input  wire logic [PORTS-1:0] port_power_req_i,
  output logic      [PORTS-1:0] downstream_port_power_o,
  output logic      [PORTS-1:0] port_power_good_o,
  output logic      [PORTS-1:0] port_enable_o,
  output logic                  phy_enable_o,
  output logic                  osc_enable_o,
  output logic                  pll_enable_o,
  output logic                  operational_o,
  output logic                  usb_attach_o,
  input  wire logic             host_req_i,
  input  wire logic             host_req_done_i,
  output logic                  req_overdue_o,
  output logic      [8:0]       current_self_ma_o,
  output logic      [8:0]       current_bus_ma_o
);

  // ============================================================
  // declarations
  hrc_state_t       state_reg;
  hrc_state_t       state_next;
  logic [31:0]      cnt_reg;
  logic [31:0]      tick_cnt_reg;
  logic             tick_reg;
  logic [7:0]       cur_self_reg;
  logic [7:0]       cur_bus_reg;
  logic [7:0]       pwr_dly_reg;
  logic [PORTS-1:0] strap_reg;
  logic [PORTS-1:0] req_d_reg;
  logic [7:0]       pcnt_reg [PORTS];
  logic             wait_reg;
  logic [31:0]      rdata_reg;
  logic             attach_reg;
  logic             oper_reg;
  logic             load_reg;
  logic             rpend_reg;
  logic [31:0]      rcnt_reg;
  logic             overdue_reg;
  logic [PORTS-1:0] pgood_reg;
  logic [PORTS-1:0] ppwr_reg;
  logic [PORTS-1:0] led_reg;
  logic [PORTS-1:0] led_oe_reg;
  logic             osc_reg;

  function automatic logic [8:0] to_ma(input logic [7:0] v);
    to_ma = {v, 1'b0};
  endfunction

  // ============================================================
  // register bus decode
  wire [5:0]  bus_idx    = avs_address_i[7:2];
  wire        bus_req    = avs_read_i | avs_write_i;
  wire        wr_ack     = avs_write_i & ~wait_reg & avs_byteenable_i[0] & (avs_address_i[1:0] == 2'b00);
  wire        hit_self   = bus_idx == IDX_CUR_SELF;
  wire        hit_bus    = bus_idx == IDX_CUR_BUS;
  wire        hit_dly    = bus_idx == IDX_PWR_ON_DLY;
  wire        hit_stat   = bus_idx == IDX_STATUS;
  wire [7:0]  status_val = {1'b0, strap_mode_i ? strap_reg : {PORTS{1'b0}}, 1'b0, load_reg, attach_reg, oper_reg};
  wire [7:0]  rd_mux     = (avs_address_i[1:0] != 2'b00) ? 8'h00 :
                           hit_self ? cur_self_reg :
                           hit_bus  ? cur_bus_reg  :
                           hit_dly  ? pwr_dly_reg  :
                           hit_stat ? status_val   : 8'h00;    // [RULE5]
  wire        load_dflt  = state_reg == ST_LOAD && (strap_mode_i || smbus_off_i);
  wire        load_ext   = state_reg == ST_LOAD && !strap_mode_i && !smbus_off_i;
  wire        load_end   = load_dflt || cfg_load_done_i || cnt_reg >= LOAD_MAX_CYC_P - 1;

  // one wait state: waitrequest drops in the cycle after a request is seen
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_reg  <= 1'b1;                                       // [RULE13]
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg  <= ~wait_reg | ~bus_req;
      rdata_reg <= (avs_read_i && wait_reg) ? {24'h000000, rd_mux} : 32'h0000_0000;
    end
  end

  // unmapped writes fall through every branch and store nothing
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_self_reg <= REG_RESET;                               // [RULE14]
      cur_bus_reg  <= REG_RESET;
      pwr_dly_reg  <= REG_RESET;
    end else if (load_dflt) begin
      cur_self_reg <= DEF_CURRENT;                             // [RULE2] [RULE8]
      cur_bus_reg  <= DEF_CURRENT;
      pwr_dly_reg  <= DEF_PWR_ON_DLY;
    end else if (wr_ack) begin                                 // [RULE6]
      if (hit_self) begin
        cur_self_reg <= avs_writedata_i[7:0];
      end
      if (hit_bus) begin
        cur_bus_reg <= avs_writedata_i[7:0];
      end
      if (hit_dly) begin
        pwr_dly_reg <= avs_writedata_i[7:0];
      end
    end
  end

  // ============================================================
  // start-up sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_STRAP: begin
        state_next = ST_RECOV;
      end
      ST_RECOV: begin
        if (cnt_reg >= RECOVER_CYC_P - 1) begin
          state_next = ST_LOAD;                                // [RULE16]
        end
      end
      ST_LOAD: begin
        if (load_end) begin
          state_next = ST_ATTACH;                              // [RULE17]
        end
      end
      ST_ATTACH: begin
        state_next = ST_RUN;                                   // [RULE18]
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_STRAP;
      cnt_reg   <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_next != state_reg) ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
    end
  end

  // straps are caught on the first edge after release, never under the reset itself
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_reg  <= '0;
      oper_reg   <= 1'b0;
      attach_reg <= 1'b0;
      load_reg   <= 1'b0;
      osc_reg    <= 1'b0;                                      // [RULE15]
    end else begin
      if (state_reg == ST_STRAP) begin
        strap_reg <= led_green_i;                              // [RULE9]
      end
      osc_reg    <= 1'b1;
      oper_reg   <= oper_reg | (state_next == ST_LOAD);        // [RULE16]
      load_reg   <= load_ext && !load_end;                     // [RULE17]
      attach_reg <= attach_reg | (state_reg == ST_ATTACH);     // [RULE18]
    end
  end

  // ============================================================
  // port power sequencing on a 2ms enable
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= tick_cnt_reg == UNIT_CYC_P - 1;
      tick_cnt_reg <= (tick_cnt_reg == UNIT_CYC_P - 1) ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end
  end

  // delay granularity is one tick: good comes N..N+1 steps after the request
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_d_reg <= '0;
      ppwr_reg  <= '0;                                         // [RULE12]
      pgood_reg <= '0;
      for (int i = 0; i < PORTS; i++) begin
        pcnt_reg[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        req_d_reg[i] <= port_power_req_i[i] & oper_reg;
        ppwr_reg[i]  <= port_power_req_i[i] & oper_reg;
        if (port_power_req_i[i] && oper_reg && !req_d_reg[i]) begin
          pcnt_reg[i]  <= pwr_dly_reg;                         // [RULE4]
          pgood_reg[i] <= 1'b0;
        end else if (!req_d_reg[i]) begin
          pgood_reg[i] <= 1'b0;
        end else if (tick_reg) begin
          if (pcnt_reg[i] == 8'h00) begin
            pgood_reg[i] <= 1'b1;
          end else begin
            pcnt_reg[i] <= pcnt_reg[i] - 8'h01;
          end
        end
      end
    end
  end

  // ============================================================
  // indicators, request watchdog, current reporting
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      led_reg     <= '0;
      led_oe_reg  <= '0;                                       // [RULE15]
      rpend_reg   <= 1'b0;
      rcnt_reg    <= 32'h0000_0000;
      overdue_reg <= 1'b0;
    end else begin
      led_reg    <= led_on_i ^ strap_reg;                      // [RULE10]
      led_oe_reg <= {PORTS{oper_reg}};
      if (host_req_i && attach_reg) begin
        rpend_reg   <= 1'b1;
        rcnt_reg    <= 32'h0000_0000;
        overdue_reg <= 1'b0;
      end else if (host_req_done_i) begin
        rpend_reg <= 1'b0;
      end else if (rpend_reg) begin
        rcnt_reg    <= rcnt_reg + 32'h0000_0001;
        overdue_reg <= overdue_reg | (rcnt_reg >= REQ_MAX_CYC_P - 1);  // [RULE20]
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      current_self_ma_o <= 9'h000;
      current_bus_ma_o  <= 9'h000;
    end else begin
      current_self_ma_o <= to_ma(cur_self_reg);                // [RULE1]
      current_bus_ma_o  <= to_ma(cur_bus_reg);                 // [RULE3]
    end
  end

  // ============================================================
  // outputs
  assign avs_readdata_o          = rdata_reg;
  assign avs_waitrequest_o       = wait_reg;
  assign cfg_load_req_o          = load_reg;
  assign led_green_o             = led_reg;
  assign led_green_oe_o          = led_oe_reg;
  assign downstream_port_power_o = ppwr_reg;
  assign port_power_good_o       = pgood_reg;
  assign port_enable_o           = pgood_reg;                  // [RULE12]
  assign phy_enable_o            = oper_reg;
  assign osc_enable_o            = osc_reg;
  assign pll_enable_o            = osc_reg;
  assign operational_o           = oper_reg;
  assign usb_attach_o            = attach_reg;
  assign req_overdue_o           = overdue_reg;

  // ============================================================
  // assertions
  property p_undef_read;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    avs_read_i && wait_reg && !(hit_self || hit_bus || hit_dly || hit_stat) |=> avs_readdata_o == 32'h0000_0000;
  endproperty
  a_undef_read: assert property (p_undef_read) else $error("undefined read not zero"); // [RULE5]

  property p_undef_write;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    avs_write_i && !wait_reg && !(hit_self || hit_bus || hit_dly) && state_reg != ST_LOAD
      |=> $stable(cur_self_reg) && $stable(cur_bus_reg) && $stable(pwr_dly_reg);
  endproperty
  a_undef_write: assert property (p_undef_write) else $error("undefined write changed state"); // [RULE6]

  property p_reset_vals;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    state_reg == ST_STRAP |-> cur_self_reg == 8'h00 && pwr_dly_reg == 8'h00 && !avs_waitrequest_o == 1'b0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("register not at reset value"); // [RULE14]

  property p_strap_dflt;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    state_reg == ST_LOAD && strap_mode_i |=> cur_self_reg == 8'h32 && cur_bus_reg == 8'h32 ##1 usb_attach_o;
  endproperty
  a_strap_dflt: assert property (p_strap_dflt) else $error("strap defaults or attach missing"); // [RULE2]

  property p_no_power;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    !operational_o |-> downstream_port_power_o == '0 && port_enable_o == '0 && !phy_enable_o;
  endproperty
  a_no_power: assert property (p_no_power) else $error("port powered before operational"); // [RULE12]

  property p_led_pol;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    state_reg == ST_RUN |=> led_green_o == ($past(led_on_i) ^ strap_reg);
  endproperty
  a_led_pol: assert property (p_led_pol) else $error("indicator polarity wrong"); // [RULE10]

  property p_oper_time;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(operational_o) |-> $past(state_reg) == ST_RECOV && $past(cnt_reg) == RECOVER_CYC_P - 1;
  endproperty
  a_oper_time: assert property (p_oper_time) else $error("operational at wrong time"); // [RULE16]

  property p_ma;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> current_self_ma_o == {$past(cur_self_reg), 1'b0} && current_bus_ma_o == {$past(cur_bus_reg), 1'b0};
  endproperty
  a_ma: assert property (p_ma) else $error("current report not 2mA steps"); // [RULE1]

  property p_ext_load;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(operational_o) && !strap_mode_i && !smbus_off_i && !cfg_load_done_i |=> cfg_load_req_o;
  endproperty
  a_ext_load: assert property (p_ext_load) else $error("external load not requested"); // [RULE17]

  property p_overdue;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    rpend_reg && !host_req_i && !host_req_done_i && rcnt_reg == REQ_MAX_CYC_P - 1 |=> req_overdue_o;
  endproperty
  a_overdue: assert property (p_overdue) else $error("late request not flagged"); // [RULE20]

  property p_attach_after_load;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    state_reg == ST_ATTACH |=> usb_attach_o && !cfg_load_req_o;
  endproperty
  a_attach_after_load: assert property (p_attach_after_load) else $error("attach not shown after load"); // [RULE18]

  c_read:   cover property (@(posedge sys_clk_i) disable iff (!resetn_i) avs_read_i && !avs_waitrequest_o);
  c_write:  cover property (@(posedge sys_clk_i) disable iff (!resetn_i) wr_ack && hit_dly);
  c_attach: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) $rose(usb_attach_o));
  c_pgood:  cover property (@(posedge sys_clk_i) disable iff (!resetn_i) $rose(port_power_good_o[0]));

endmodule
`default_nettype wire

// *** dv/hrc_host_model.sv ***
// behavioural model of the configuration loader and upstream host
`timescale 1ns/100ps
`default_nettype none
module hrc_host_model #(
  parameter int unsigned LOAD_DLY = 10,
  parameter int unsigned ATT_WAIT = 16
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       cfg_load_req_i,
  input  wire logic       usb_attach_i,
  input  wire logic       req_go_i,
  input  wire logic [7:0] resp_dly_i,
  output logic            cfg_load_done_o,
  output logic            host_req_o,
  output logic            host_req_done_o
);
  // ============================================================
  // loader answers, then host requests after its attach wait
  logic [7:0] ldc;
  logic [7:0] att_cnt;
  logic [7:0] rc;
  logic       busy;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ldc <= 8'h00;
      att_cnt <= 8'h00;
      rc <= 8'h00;
      busy <= 1'b0;
      cfg_load_done_o <= 1'b0;
      host_req_o <= 1'b0;
      host_req_done_o <= 1'b0;
    end else begin
      cfg_load_done_o <= cfg_load_req_i && (ldc == 8'(LOAD_DLY));
      ldc <= cfg_load_req_i ? ldc + 8'h01 : 8'h00;
      if (usb_attach_i && att_cnt != 8'(ATT_WAIT)) begin
        att_cnt <= att_cnt + 8'h01;
      end
      // scaled-down settle time: no request until the wait after attach is over
      host_req_o <= req_go_i && !busy && !host_req_o && (att_cnt == 8'(ATT_WAIT));
      host_req_done_o <= busy && (rc == resp_dly_i);
      if (host_req_o) begin
        busy <= 1'b1;
        rc <= 8'h00;
      end else if (busy) begin
        rc <= rc + 8'h01;
        if (rc == resp_dly_i) begin
          busy <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/hrc_top_tb.sv ***
// self-checking bench for the hub reset and configuration block
`timescale 1ns/100ps
`default_nettype none
module hrc_top_tb;
  import hrc_pkg::*;
  localparam int RCV = 20;
  localparam int UC  = 8;
  // ============================================================
  // signals
  logic        sys_clk_i, resetn_i, avs_read_i, avs_write_i, strap_mode_i, smbus_off_i, go;
  logic [7:0]  avs_address_i, resp_dly;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [2:0]  strap, led_on_i, port_power_req_i;
  wire  logic [2:0]  led_green_i, led_green_o, led_green_oe_o;
  wire  logic [2:0]  downstream_port_power_o, port_power_good_o, port_enable_o;
  wire  logic [31:0] avs_readdata_o;
  wire  logic [8:0]  current_self_ma_o, current_bus_ma_o;
  wire  logic        avs_waitrequest_o, cfg_load_done_i, cfg_load_req_o, phy_enable_o, osc_enable_o;
  wire  logic        pll_enable_o, operational_o, usb_attach_o, host_req_i, host_req_done_i, req_overdue_o;
  int          errors, checked;

  // pin level: the hub drives when enabled, otherwise the strap resistor wins
  assign led_green_i = (led_green_oe_o & led_green_o) | (~led_green_oe_o & strap);

  hrc_top #(.RECOVER_CYC_P(RCV), .UNIT_CYC_P(UC), .LOAD_MAX_CYC_P(50), .REQ_MAX_CYC_P(30)) dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .strap_mode_i(strap_mode_i), .smbus_off_i(smbus_off_i),
    .cfg_load_done_i(cfg_load_done_i), .cfg_load_req_o(cfg_load_req_o), .led_green_i(led_green_i),
    .led_on_i(led_on_i), .led_green_o(led_green_o), .led_green_oe_o(led_green_oe_o),
    .port_power_req_i(port_power_req_i), .downstream_port_power_o(downstream_port_power_o),
    .port_power_good_o(port_power_good_o), .port_enable_o(port_enable_o), .phy_enable_o(phy_enable_o),
    .osc_enable_o(osc_enable_o), .pll_enable_o(pll_enable_o), .operational_o(operational_o),
    .usb_attach_o(usb_attach_o), .host_req_i(host_req_i), .host_req_done_i(host_req_done_i),
    .req_overdue_o(req_overdue_o), .current_self_ma_o(current_self_ma_o), .current_bus_ma_o(current_bus_ma_o));

  hrc_host_model partner (
    .clk_i(sys_clk_i), .resetn_i(resetn_i), .cfg_load_req_i(cfg_load_req_o), .usb_attach_i(usb_attach_o),
    .req_go_i(go), .resp_dly_i(resp_dly), .cfg_load_done_o(cfg_load_done_i), .host_req_o(host_req_i),
    .host_req_done_o(host_req_done_i));

  // ============================================================
  // helpers
  task automatic print_verdict;
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address_i <= a;
    avs_writedata_i <= d;
    if (w) avs_write_i <= 1'b1;
    else avs_read_i <= 1'b1;
    do begin @(posedge sys_clk_i); end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h000000, d}, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(q, exp);
  endtask

  // ============================================================
  // scenarios
  task automatic do_reset(input logic sm, input logic off);
    int n;
    strap_mode_i <= sm;
    smbus_off_i <= off;
    resetn_i <= 1'b0;
    tick(12);
    chk({downstream_port_power_o, port_enable_o, led_green_oe_o, phy_enable_o}, 32'h0);
    chk({osc_enable_o, pll_enable_o, led_green_oe_o, operational_o, usb_attach_o}, 32'h0);
    resetn_i <= 1'b1;
    n = 0;
    do begin @(posedge sys_clk_i); n++; end while (operational_o !== 1'b1 && n < 100);
    chk(n >= RCV && n <= RCV + 3, 1);
    chk({osc_enable_o, pll_enable_o, phy_enable_o}, 32'h7);
  endtask

  task automatic t_strap;
    int n;
    n = 0;
    while (usb_attach_o !== 1'b1 && n < 20) begin @(posedge sys_clk_i); n++; end
    chk(n <= 4, 1);
    rd_chk(8'h38, {24'h0, DEF_CURRENT});
    rd_chk(8'h3c, 32'h32);
    rd_chk(8'h40, {24'h0, DEF_PWR_ON_DLY});
    chk(current_self_ma_o, 9'd100);
    chk(current_bus_ma_o, 9'd100);
    rd_chk(8'h44, {25'h0, strap, 4'h3});
    led_on_i <= 3'b011;
    tick(3);
    chk(led_green_oe_o, 3'b111);
    chk(led_green_o, strap ^ 3'b011);
  endtask

  task automatic t_regs;
    wr8(8'h38, 8'h0a);
    wr8(8'h3c, 8'hff);
    wr8(8'h48, 8'h55);
    wr8(8'h39, 8'h77);
    wr8(8'h44, 8'h00);
    wr8(8'h00, 8'h11);
    rd_chk(8'h38, 32'h0a);
    rd_chk(8'h3c, 32'hff);
    rd_chk(8'h44, {25'h0, strap, 4'h3});
    rd_chk(8'h48, 32'h0);
    rd_chk(8'h39, 32'h0);
    rd_chk(8'hfc, 32'h0);
    chk(current_self_ma_o, 9'd20);
    chk(current_bus_ma_o, 9'd510);
  endtask

  task automatic t_power;
    int n;
    int d;
    for (d = 0; d < 4; d += 3) begin
      wr8(8'h40, 8'(d));
      port_power_req_i <= 3'b010;
      n = 0;
      do begin @(posedge sys_clk_i); n++; end while (downstream_port_power_o[1] !== 1'b1 && n < 10);
      chk(n <= 2, 1);
      while (port_power_good_o[1] !== 1'b1 && n < 100) begin @(posedge sys_clk_i); n++; end
      chk(n >= d * UC && n <= (d + 1) * UC + 3, 1);
      chk(port_enable_o, 3'b010);
      port_power_req_i <= 3'b000;
      tick(3);
      chk({downstream_port_power_o, port_power_good_o}, 32'h0);
    end
  endtask

  task automatic t_host;
    int n;
    tick(20);
    resp_dly <= 8'd40;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    n = 0;
    while (req_overdue_o !== 1'b1 && n < 60) begin @(posedge sys_clk_i); n++; end
    chk(n >= 30 && n <= 36, 1);
    tick(20);
    resp_dly <= 8'd4;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(15);
    chk(req_overdue_o, 1'b0);
  endtask

  task automatic t_abort_load;
    int n;
    avs_address_i <= 8'h38;
    avs_read_i <= 1'b1;
    tick(1);
    resetn_i <= 1'b0;
    @(negedge sys_clk_i);
    chk({avs_waitrequest_o, avs_readdata_o[7:0]}, 32'h100);
    @(posedge sys_clk_i);
    avs_read_i <= 1'b0;
    do_reset(1'b0, 1'b0);
    n = 0;
    while (cfg_load_req_o !== 1'b1 && n < 10) begin @(posedge sys_clk_i); n++; end
    chk(cfg_load_req_o, 1'b1);
    while (usb_attach_o !== 1'b1 && n < 40) begin @(posedge sys_clk_i); n++; end
    chk({usb_attach_o, cfg_load_req_o}, 32'h2);
    rd_chk(8'h38, 32'h0);
    rd_chk(8'h44, 32'h3);
    do_reset(1'b0, 1'b1);
    tick(4);
    chk(cfg_load_req_o, 1'b0);
    rd_chk(8'h3c, 32'h32);
  endtask

  // ============================================================
  // clock, sequence and watchdog
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    errors = 0;
    checked = 0;
    resetn_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h1;
    strap_mode_i = 1'b1;
    smbus_off_i = 1'b0;
    go = 1'b0;
    resp_dly = 8'd4;
    strap = 3'b101;
    led_on_i = 3'b000;
    port_power_req_i = 3'b000;
    do_reset(1'b1, 1'b0);
    t_strap;
    t_regs;
    t_power;
    t_host;
    t_abort_load;
    print_verdict;
  end

  // whole run needs well under two thousand cycles
  initial begin
    tick(5000);
    errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
